// ==== shared/dbu_pkg.sv ====
// Shared constants, types and decode for the delayed branch unit.
// Assumes 16-bit instruction words and a 32-bit program counter.
package dbu_pkg;

  // ****************************************
  // Encodings and timing counts
  // ****************************************
  localparam logic [3:0]  DBU_FAR_HI     = 4'h0;   // Far forms, top nibble
  localparam logic [7:0]  DBU_FAR_BR_LO  = 8'h23;  // Far relative branch
  localparam logic [7:0]  DBU_FAR_CL_LO  = 8'h03;  // Far subroutine call
  localparam logic [3:0]  DBU_REL_CL_HI  = 4'hB;   // Relative call
  localparam logic [7:0]  DBU_BT_HI      = 8'h89;  // Branch if flag set
  localparam logic [31:0] DBU_REF_OFS    = 32'h0000_0004; // Ref PC offset
  localparam logic [1:0]  DBU_BT_EXTRA   = 2'h2;   // Taken: 3 cycles total
  localparam logic [31:0] DBU_PC_RST     = 32'h0000_0000; // Reset value

  // ****************************************
  // Types
  // ****************************************
  // Kind of instruction seen by the unit
  typedef enum logic [2:0] {
    DBU_K_NONE   = 3'h0,
    DBU_K_FAR_BR = 3'h1,
    DBU_K_REL_CL = 3'h2,
    DBU_K_FAR_CL = 3'h3,
    DBU_K_BT     = 3'h4
  } dbu_kind_t;

  // Gray-coded sequencer states
  typedef enum logic [1:0] {
    DBU_S_IDLE  = 2'b00,
    DBU_S_STALL = 2'b01,
    DBU_S_SLOT  = 2'b11,
    DBU_S_BTW   = 2'b10
  } dbu_state_t;

  // Instruction handed over by decode
  typedef struct packed {
    logic        valid;    // Word present
    logic [15:0] word;     // Instruction word
    logic [31:0] pc;       // Its own address
    logic [31:0] src_val;  // Source register, field [11:8]
    logic        t_flag;   // Condition flag
    logic        other_br; // Some other branch form
  } dbu_inst_t;

  // Control toward execute and exception logic
  typedef struct packed {
    logic        redirect;     // Pulse: load target into PC
    logic [31:0] target;       // Branch target
    logic        ret_wr;       // Pulse: write return address
    logic [31:0] ret_val;      // Return address value
    logic        int_block;    // Level: refuse interrupts
    logic        aerr_block;   // Level: refuse address errors
    logic        illegal_slot; // Pulse: illegal slot exception
    logic        suppress;     // Pulse: do not execute that word
    logic        recover;      // Pulse: re-execute the call
    logic [31:0] recover_pc;   // Address of the call
  } dbu_ctl_t;

  // ****************************************
  // Decode
  // ****************************************
  // Classify one instruction word
  function automatic dbu_kind_t dbu_decode(input logic [15:0] w);
    dbu_kind_t k;
    k = DBU_K_NONE;
    if (w[15:12] == DBU_FAR_HI && w[7:0] == DBU_FAR_BR_LO) begin
      k = DBU_K_FAR_BR;
    end else if (w[15:12] == DBU_FAR_HI && w[7:0] == DBU_FAR_CL_LO) begin
      k = DBU_K_FAR_CL;
    end else if (w[15:12] == DBU_REL_CL_HI) begin
      k = DBU_K_REL_CL;
    end else if (w[15:8] == DBU_BT_HI) begin
      k = DBU_K_BT;
    end
    return k;
  endfunction

endpackage

// ==== hw/dbu_target_calc.sv ====
// Branch target arithmetic for the delayed branch unit.
// Assumes the source register value is read before any slot update.
`timescale 1ns/10ps
module dbu_target_calc (
  // Instruction
  input  wire logic [15:0]         word,
  input  wire logic [31:0]         pc,
  input  wire logic [31:0]         src_val,
  input  wire dbu_pkg::dbu_kind_t  kind,
  // Results
  output logic      [31:0]         ref_pc,
  output logic      [31:0]         target
);

  // ****************************************
  // Displacements
  // ****************************************
  logic [31:0] disp12;  // Sign-extended, doubled 12-bit
  logic [31:0] disp8;   // Sign-extended, doubled 8-bit

  // Second instruction after the branch
  // RULE3: reference PC
  assign ref_pc = pc + dbu_pkg::DBU_REF_OFS;

  // RULE6: doubled 12-bit
  assign disp12 = {{19{word[11]}}, word[11:0], 1'b0};
  // RULE12: doubled 8-bit
  assign disp8  = {{23{word[7]}}, word[7:0], 1'b0};

  // Target by kind
  always_comb begin
    case (kind)
      // RULE2: plus source register
      dbu_pkg::DBU_K_FAR_BR: target = ref_pc + src_val;
      // RULE10: plus source register
      dbu_pkg::DBU_K_FAR_CL: target = ref_pc + src_val;
      dbu_pkg::DBU_K_REL_CL: target = ref_pc + disp12;
      dbu_pkg::DBU_K_BT:     target = ref_pc + disp8;
      default:               target = ref_pc;
    endcase
  end

endmodule

// ==== hw/dbu_branch_unit.sv ====
// Delayed branch unit: sequencing, slot checks and control pulses.
// Assumes decode offers one word per cycle when ready is high and
// that the register file reads field [11:8] in the same cycle.
// Exception inputs are looked at while a call waits for its slot;
// a re-execution exception with no fetch exception then restarts the call.
//
// Function
// RULE1: slot first, target from pre-slot registers
// RULE2: far branch adds source register, 2 cycles
// RULE3: reference PC is branch address plus four
// RULE4: far branch blocks interrupts, address errors
// RULE5: branch after unconditional branch is illegal
// RULE6: relative call saves PC, doubled displacement
// RULE7: calls block interrupts until slot
// RULE8: slot sees updated return address
// RULE9: return address kept; call re-executed
// RULE10: far call saves PC, adds register
// RULE11: flag set branches, no delay slot
// RULE12: eight-bit displacement sign-extended, doubled
// RULE13: taken three cycles, not taken one
// RULE14: these branches in slot are illegal
// RULE15: illegal slot suppressed, exception raised
`timescale 1ns/10ps
module dbu_branch_unit (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // Instruction from decode
  input  wire dbu_pkg::dbu_inst_t  inst,
  // Slot exception report from execute
  input  wire logic                slot_reexec_exc,
  input  wire logic                slot_fetch_exc,
  // Flow control toward decode
  output logic                     inst_ready,
  // Control toward execute and exceptions
  output dbu_pkg::dbu_ctl_t        ctl
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dbu_pkg::dbu_state_t st;       // Sequencer state
    logic [1:0]          cnt;      // Stall count for taken flag branch
    logic [31:0]         target;   // Captured target
    logic [31:0]         ret;      // Captured return address
    logic [31:0]         br_pc;    // Address of the pending branch
    logic                is_call;  // Pending branch is a call
    logic                is_far;   // Pending far relative branch
    logic                ready;    // Word accept flag
    dbu_pkg::dbu_ctl_t   ctl;      // Registered control outputs
  } dbu_regs_t;

  dbu_regs_t          state_r;    // Registered state
  dbu_regs_t          state_nxt;  // Next state
  dbu_pkg::dbu_kind_t kind;       // Kind of offered word
  logic [31:0]        ref_pc;     // Reference PC of offered word
  logic [31:0]        target;     // Target of offered word
  logic               take;       // Word accepted this cycle
  logic               slot_br;    // Offered word is any branch

  // ****************************************
  // Decode and target arithmetic
  // ****************************************
  // Classify the offered word
  assign kind    = dbu_pkg::dbu_decode(inst.word);
  // Handshake with decode
  assign take    = inst.valid && state_r.ready;
  // Any branch form, ours or not
  assign slot_br = (kind != dbu_pkg::DBU_K_NONE) || inst.other_br;

  // Target from the registers as offered now
  dbu_target_calc u_calc (
    .word    (inst.word),
    .pc      (inst.pc),
    .src_val (inst.src_val),
    .kind    (kind),
    .ref_pc  (ref_pc),
    .target  (target)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    // Hold everything by default
    state_nxt = state_r;
    // Pulses last one cycle
    state_nxt.ctl.redirect     = 1'b0;
    state_nxt.ctl.ret_wr       = 1'b0;
    state_nxt.ctl.illegal_slot = 1'b0;
    state_nxt.ctl.suppress     = 1'b0;
    state_nxt.ctl.recover      = 1'b0;
    // Sequencer
    case (state_r.st)
      // Waiting for a branch
      dbu_pkg::DBU_S_IDLE: begin
        if (take) begin
          case (kind)
            // Delayed forms: far branch and both calls
            dbu_pkg::DBU_K_FAR_BR,
            dbu_pkg::DBU_K_REL_CL,
            dbu_pkg::DBU_K_FAR_CL: begin
              // RULE1: target latched now
              state_nxt.target  = target;
              state_nxt.ret     = ref_pc;
              state_nxt.br_pc   = inst.pc;
              state_nxt.is_call = (kind != dbu_pkg::DBU_K_FAR_BR);
              state_nxt.is_far  = (kind == dbu_pkg::DBU_K_FAR_BR);
              state_nxt.st      = dbu_pkg::DBU_S_STALL;
              // RULE2: second cycle stall
              state_nxt.ready   = 1'b0;
              // RULE7: interrupts held off
              state_nxt.ctl.int_block  = 1'b1;
              // RULE4: address errors held off
              state_nxt.ctl.aerr_block = (kind == dbu_pkg::DBU_K_FAR_BR);
            end
            dbu_pkg::DBU_K_BT: begin
              // RULE11: branch only when flag set
              if (inst.t_flag) begin
                // Two more cycles before the jump
                state_nxt.target = target;
                state_nxt.cnt    = dbu_pkg::DBU_BT_EXTRA;
                state_nxt.st     = dbu_pkg::DBU_S_BTW;
                state_nxt.ready  = 1'b0;
              end else begin
                // RULE13: not taken, next word at once
                state_nxt.st     = dbu_pkg::DBU_S_IDLE;
              end
            end
            // Not a branch of ours
            default: begin
              state_nxt.st = dbu_pkg::DBU_S_IDLE;
            end
          endcase
        end
      end
      // Second cycle of a delayed branch
      dbu_pkg::DBU_S_STALL: begin
        if (state_r.is_call) begin
          // RULE8: write before slot
          state_nxt.ctl.ret_wr  = 1'b1;
          state_nxt.ctl.ret_val = state_r.ret;
        end
        // Slot word may come next cycle
        state_nxt.ready = 1'b1;
        state_nxt.st    = dbu_pkg::DBU_S_SLOT;
      end
      // Waiting for the slot word
      dbu_pkg::DBU_S_SLOT: begin
        if (take) begin
          // Blocks drop once the slot is in
          state_nxt.st             = dbu_pkg::DBU_S_IDLE;
          state_nxt.ctl.int_block  = 1'b0;
          state_nxt.ctl.aerr_block = 1'b0;
          if (slot_br) begin
            // RULE5: branch in slot
            // RULE14: ours in slot
            // RULE15: suppress and raise
            state_nxt.ctl.illegal_slot = 1'b1;
            state_nxt.ctl.suppress     = 1'b1;
          end else begin
            // RULE1: transfer after slot
            state_nxt.ctl.redirect = 1'b1;
            state_nxt.ctl.target   = state_r.target;
          end
        end
      end
      // Extra cycles of a taken flag branch
      dbu_pkg::DBU_S_BTW: begin
        // RULE13: three cycles taken
        state_nxt.cnt = state_r.cnt - 2'h1;
        if (state_r.cnt == 2'h1) begin
          // Jump on the last extra cycle
          state_nxt.ctl.redirect = 1'b1;
          state_nxt.ctl.target   = state_r.target;
          state_nxt.ready        = 1'b1;
          state_nxt.st           = dbu_pkg::DBU_S_IDLE;
        end
      end
      // Unused code
      default: begin
        state_nxt.st    = dbu_pkg::DBU_S_IDLE;
        state_nxt.ready = 1'b1;
      end
    endcase
    // RULE9: keep return address, re-run call
    // Only while a call's slot is pending, never for a stale call
    if (slot_reexec_exc && !slot_fetch_exc && state_r.is_call &&
        state_r.st == dbu_pkg::DBU_S_SLOT) begin
      state_nxt.ctl.recover    = 1'b1;
      state_nxt.ctl.recover_pc = state_r.br_pc;
      state_nxt.ctl.redirect   = 1'b0;
      // Back to idle so the re-run call is not taken as a slot
      state_nxt.st             = dbu_pkg::DBU_S_IDLE;
      state_nxt.ready          = 1'b1;
      state_nxt.ctl.int_block  = 1'b0;
      state_nxt.ctl.aerr_block = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Outputs quiet, pulses low
      state_r                <= '0;
      state_r.st             <= dbu_pkg::DBU_S_IDLE;
      // Ready to take a word out of reset
      state_r.ready          <= 1'b1;
      state_r.target         <= dbu_pkg::DBU_PC_RST;
      state_r.ctl.target     <= dbu_pkg::DBU_PC_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Both straight from the state register
  assign inst_ready = state_r.ready;
  assign ctl        = state_r.ctl;

endmodule

// ==== tb/dbu_branch_unit_sva.sv ====
// Checker for the delayed branch unit.
// Assumes it is bound to dbu_branch_unit.
`timescale 1ns/10ps
module dbu_branch_unit_sva (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               reset_n,
  // Watched ports
  input wire dbu_pkg::dbu_inst_t inst,
  input wire logic               slot_reexec_exc,
  input wire logic               slot_fetch_exc,
  input wire logic               inst_ready,
  input wire dbu_pkg::dbu_ctl_t  ctl
);
  // ****************
  // Decode helpers
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic tk, fb, fc, rc, bt, br, slt; // Take, kinds, slot take
  assign tk  = inst.valid && inst_ready;
  assign fb  = inst.word[15:12] == 4'h0 && inst.word[7:0] == 8'h23;
  assign fc  = inst.word[15:12] == 4'h0 && inst.word[7:0] == 8'h03;
  assign rc  = inst.word[15:12] == 4'hB;
  assign bt  = inst.word[15:8] == 8'h89;
  assign br  = fb || fc || rc || bt || inst.other_br;
  assign slt = tk && ctl.int_block;
  // ****************
  // Properties
  // ****************
  sequence s_hold2;
    !inst_ready [*2];
  endsequence
  property p_bt_t;
    tk && bt && inst.t_flag && !ctl.int_block
      |=> s_hold2 ##1 (inst_ready && ctl.redirect);
  endproperty
  a_bt_t: assert property (p_bt_t) else $error("taken flag branch");
  property p_bt_n;
    tk && bt && !inst.t_flag && !ctl.int_block
      |=> inst_ready && !ctl.redirect;
  endproperty
  a_bt_n: assert property (p_bt_n) else $error("flag branch not taken");
  property p_dly;
    tk && (fb || fc || rc) && !ctl.int_block
      |=> (!inst_ready && ctl.int_block) ##1 inst_ready;
  endproperty
  a_dly: assert property (p_dly) else $error("delayed branch block");
  property p_aerr;
    tk && fb && !ctl.int_block |=> ctl.aerr_block;
  endproperty
  a_aerr: assert property (p_aerr) else $error("address error open");
  property p_ret;
    tk && (fc || rc) && !ctl.int_block |-> ##2 ctl.ret_wr
      && ctl.ret_val == $past(inst.pc, 2) + 32'h0000_0004;
  endproperty
  a_ret: assert property (p_ret) else $error("return address");
  property p_ill;
    slt && br |=> ctl.illegal_slot && ctl.suppress && !ctl.redirect;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal slot missed");
  property p_go;
    slt && !br && !slot_reexec_exc |=> ctl.redirect && !ctl.illegal_slot;
  endproperty
  a_go: assert property (p_go) else $error("no jump after slot");
  property p_unblk;
    slt |=> !ctl.int_block && !ctl.aerr_block;
  endproperty
  a_unblk: assert property (p_unblk) else $error("block held");
endmodule

bind dbu_branch_unit dbu_branch_unit_sva chk_u (.mclk(mclk),
  .reset_n(reset_n), .inst(inst), .slot_reexec_exc(slot_reexec_exc),
  .slot_fetch_exc(slot_fetch_exc), .inst_ready(inst_ready), .ctl(ctl));

// ==== tb/dbu_core_model.sv ====
// Core side model: program counter and return address.
// Assumes control pulses from the delayed branch unit.
`timescale 1ns/10ps
module dbu_core_model (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Control from the unit
  input  wire dbu_pkg::dbu_ctl_t ctl,
  // Core state
  output logic [31:0]            pc_r,
  output logic [31:0]            ret_addr_r
);
  // Follow redirects, return writes and recovery
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r       <= 32'h0000_0000;
      ret_addr_r <= 32'h0000_0000;
    end else begin
      if (ctl.ret_wr) ret_addr_r <= ctl.ret_val;
      if (ctl.recover) pc_r <= ctl.recover_pc;
      else if (ctl.redirect) pc_r <= ctl.target;
    end
  end
endmodule

// ==== tb/delayed_branch_unit_tb_top.sv ====
// Testbench for the delayed branch unit.
// Assumes package, checker and core model are compiled first.
`timescale 1ns/10ps
module delayed_branch_unit_tb_top;
  // Case row: stimulus, then expected results
  typedef struct packed {
    logic [15:0] w;  logic [31:0] p, s;  logic t, hs;  logic [15:0] sw;
    logic er;  logic [31:0] et;  logic ew;  logic [31:0] ev;  logic ei;
  } dbu_row_t;
  logic               mclk, reset_n, slot_reexec_exc, slot_fetch_exc;
  logic               inst_ready;
  dbu_pkg::dbu_inst_t inst;
  dbu_pkg::dbu_ctl_t  ctl;
  logic [31:0]        pc_r, ret_addr_r, gt, gp, bp;
  logic               sr, sw_, si, sc;   // Pulses seen
  logic               ob;                // Other branch form offered
  int                 err_count, cmp_count, cyc;
  dbu_row_t           rows [9];
  dbu_row_t           r;
  dbu_branch_unit dut_u (.mclk(mclk), .reset_n(reset_n), .inst(inst),
    .slot_reexec_exc(slot_reexec_exc), .slot_fetch_exc(slot_fetch_exc),
    .inst_ready(inst_ready), .ctl(ctl));
  dbu_core_model core_u (.mclk(mclk), .reset_n(reset_n), .ctl(ctl),
    .pc_r(pc_r), .ret_addr_r(ret_addr_r));
  // ****************
  // Clock and timeout
  // ****************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One cycle, sampling pulses at the falling edge
  task automatic step;
    @(negedge mclk);
    if (ctl.redirect === 1'b1) begin
      sr = 1'b1;
      gt = ctl.target;
    end
    if (ctl.ret_wr === 1'b1) sw_ = 1'b1;
    if (ctl.illegal_slot === 1'b1 && ctl.suppress === 1'b1) si = 1'b1;
    if (ctl.recover === 1'b1) begin
      sc = 1'b1;
      gp = ctl.recover_pc;
    end
  endtask
  // Offer a word and hold it until taken
  task automatic send(input logic [15:0] w, input logic [31:0] p, s,
                      input logic t);
    int n;
    inst = '{1'b1, w, p, s, t, ob};
    n = 0;
    while (inst_ready !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    step();
  endtask
  task automatic finish_op;
    inst.valid = 1'b0;
    repeat (4) step();
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    rows = '{
      '{16'h0123, 32'h0000_1000, 32'h0000_0100, 1'b0, 1'b1, 16'h0009,
        1'b1, 32'h0000_1104, 1'b0, 32'h0000_0000, 1'b0},
      '{16'hB7FF, 32'h0000_2000, 32'h0000_0000, 1'b0, 1'b1, 16'h0009,
        1'b1, 32'h0000_3002, 1'b1, 32'h0000_2004, 1'b0},
      '{16'hB800, 32'h0000_3000, 32'h0000_0000, 1'b0, 1'b1, 16'h0009,
        1'b1, 32'h0000_2004, 1'b1, 32'h0000_3004, 1'b0},
      '{16'h0203, 32'h0000_4000, 32'hFFFF_FFF0, 1'b0, 1'b1, 16'h0009,
        1'b1, 32'h0000_3FF4, 1'b1, 32'h0000_4004, 1'b0},
      '{16'h897F, 32'h0000_5000, 32'h0000_0000, 1'b1, 1'b0, 16'h0000,
        1'b1, 32'h0000_5102, 1'b0, 32'h0000_0000, 1'b0},
      '{16'h8980, 32'h0000_6000, 32'h0000_0000, 1'b1, 1'b0, 16'h0000,
        1'b1, 32'h0000_5F04, 1'b0, 32'h0000_0000, 1'b0},
      '{16'h8980, 32'h0000_6000, 32'h0000_0000, 1'b0, 1'b0, 16'h0000,
        1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000, 1'b0},
      '{16'h0523, 32'h0000_8000, 32'h0000_0010, 1'b0, 1'b1, 16'h8900,
        1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000, 1'b1},
      '{16'hB010, 32'h0000_9000, 32'h0000_0000, 1'b0, 1'b1, 16'h0323,
        1'b0, 32'h0000_0000, 1'b1, 32'h0000_9004, 1'b1}};
    inst = '0;
    ob = 1'b0;
    {slot_reexec_exc, slot_fetch_exc, reset_n} = 3'h0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      {sr, sw_, si, sc} = 4'h0;
      send(r.w, r.p, r.s, r.t);
      if (r.hs) send(r.sw, r.p + 32'h2, ~r.s, 1'b0);
      finish_op();
      check("redirect", 32'(r.er), 32'(sr));
      if (r.er) check("target", r.et, gt);
      if (r.er) check("pc", r.et, pc_r);
      check("ret_wr", 32'(r.ew), 32'(sw_));
      if (r.ew) check("ret_val", r.ev, ret_addr_r);
      check("illegal", 32'(r.ei), 32'(si));
      $display("row %0d done", i);
    end
    // Slot exception after a call, fetch and non-fetch kinds
    for (int f = 0; f < 2; f++) begin
      {sr, sw_, si, sc} = 4'h0;
      slot_fetch_exc = f[0];
      bp = f[0] ? 32'h0000_7100 : 32'h0000_7000;
      send(16'hB004, bp, 32'h0000_0000, 1'b0);
      step();
      slot_reexec_exc = 1'b1;
      send(16'h0009, bp + 32'h0000_0002, 32'h0000_0000, 1'b0);
      slot_reexec_exc = 1'b0;
      finish_op();
      check("recover", 32'(!f[0]), 32'(sc));
      if (!f[0]) check("recover_pc", bp, gp);
      check("ret_kept", bp + 32'h0000_0004, ret_addr_r);
      check("pc", f[0] ? bp + 32'h0000_000C : bp, pc_r);
      $display("slot exception %0d done", f);
    end
    slot_fetch_exc = 1'b0;
    // Branch form not decoded here, in a far call's slot
    {sr, sw_, si, sc} = 4'h0;
    send(16'h0003, 32'h0000_B000, 32'h0000_0040, 1'b0);
    ob = 1'b1;
    send(16'h0009, 32'h0000_B002, 32'h0000_0000, 1'b0);
    ob = 1'b0;
    finish_op();
    check("illegal", 32'h0000_0001, 32'(si));
    check("redirect", 32'h0000_0000, 32'(sr));
    check("ret_val", 32'h0000_B004, ret_addr_r);
    $display("other branch in slot done");
    // Reset in mid-branch
    send(16'h0123, 32'hA000, 0, 1'b0);
    reset_n = 1'b0;
    inst.valid = 1'b0;
    step();
    check("rst_ctl", 0, {31'h0, |ctl});
    check("rst_ready", 32'h0000_0001, 32'(inst_ready));
    reset_n = 1'b1;
    step();
    check("int_block", 32'h0000_0000, 32'(ctl.int_block));
    $display("reset test done");
    tally_and_finish();
  end
endmodule
